// ==== logic/lgp_pkg.sv ====
// package: register map, field layout and reset values for the lcd-shared gpio
package lgp_pkg;
  // ------------------------------------------------------------
  // register byte addresses (word aligned, 32-bit data bus)
  // ------------------------------------------------------------
  localparam logic [7:0] LGP_PA_DATA_OFS  = 8'h00;
  localparam logic [7:0] LGP_PA_DIR_OFS   = 8'h04;
  localparam logic [7:0] LGP_PB_DATA_OFS  = 8'h08;
  localparam logic [7:0] LGP_PB_DIR_OFS   = 8'h0C;
  localparam logic [7:0] LGP_PA_RMW_OFS   = 8'h10;
  localparam logic [7:0] LGP_PB_RMW_OFS   = 8'h14;
  localparam logic [7:0] LGP_CTRL_OFS     = 8'h18;
  localparam logic [7:0] LGP_BP_SEL_OFS   = 8'h1C;
  localparam logic [7:0] LGP_SEG_SEL_OFS  = 8'h20;
  localparam logic [7:0] LGP_STATUS_OFS   = 8'h24;
  localparam int         LGP_ADDR_W       = 8;
  localparam int         LGP_WORD_LSB     = 2;

  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int LGP_PA_W       = 8;
  localparam int LGP_PB_W       = 5;
  localparam int LGP_CTRL_PORT_INPUT_CONTROL_BIT = 0;
  localparam int LGP_CTRL_SPL   = 1;
  localparam int LGP_CTRL_W     = 2;
  localparam int LGP_STS_STBY   = 0;
  localparam int LGP_STS_FLOAT  = 1;

  // ------------------------------------------------------------
  // reset values and bus responses
  // ------------------------------------------------------------
  localparam logic [7:0]  LGP_DIR_RST   = 8'h00;
  localparam logic [7:0]  LGP_DATA_RST  = 8'h00;
  localparam logic [7:0]  LGP_SEL_RST   = 8'h00;
  localparam logic [1:0]  LGP_CTRL_RST  = 2'h0;
  localparam logic [1:0]  LGP_RESP_OKAY = 2'h0;
  localparam logic [1:0]  LGP_RESP_SLV  = 2'h2;
  localparam logic [31:0] LGP_ZERO32    = 32'h0000_0000;

  typedef logic [LGP_PA_W-1:0] lgp_pa_t;
  typedef logic [LGP_PB_W-1:0] lgp_pb_t;
endpackage

// ==== logic/lgp_pin_if.sv ====
// interface: per-port pin control between the register file and a pin slice
`timescale 1ns/10ps
interface lgp_pin_if #(parameter int W = 8);
  logic [W-1:0] latch;     // data latch bits
  logic [W-1:0] dir;       // direction bits, 1 = output
  logic [W-1:0] lcd_sel;   // display function selected
  logic [W-1:0] lcd_val;   // display driver level
  logic         port_input_control_bit;     // port input control
  logic         floated;   // standby float active
  logic [W-1:0] pin_in;    // raw pin levels
  logic [W-1:0] pin_out;   // pin drive level
  logic [W-1:0] pin_oe;    // pin drive enable
  logic [W-1:0] sampled;   // synchronised, gated pin level
  modport ctl  (output latch, dir, lcd_sel, lcd_val, port_input_control_bit, floated,
                output pin_in, input pin_out, pin_oe, sampled);
  modport pins (input latch, dir, lcd_sel, lcd_val, port_input_control_bit, floated,
                input pin_in, output pin_out, pin_oe, sampled);
endinterface

// ==== logic/lgp_pin_slice.sv ====
// module: pin drivers and input synchroniser for one port
`timescale 1ns/10ps
module lgp_pin_slice #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // port control and pins
  lgp_pin_if.pins   p
);
  import lgp_pkg::*;

  logic [W-1:0] sync1_q;
  logic [W-1:0] sync2_q;
  logic [W-1:0] lcd_own;

  // ----------------------------------------------------------------
  // drive
  // ----------------------------------------------------------------
  // display owns a pin only with dir 0, select 1 and input control 1
  assign lcd_own = p.lcd_sel & ~p.dir & {W{p.port_input_control_bit}};

  // float wins over everything; otherwise display, then latch
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (p.floated) begin
        p.pin_oe[i]  = 1'b0;
        p.pin_out[i] = 1'b0;
      end else if (lcd_own[i]) begin
        p.pin_oe[i]  = 1'b1;
        p.pin_out[i] = p.lcd_val[i];
      end else begin
        p.pin_oe[i]  = p.dir[i];
        p.pin_out[i] = p.latch[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // two flops; the first feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= p.pin_in;
      sync2_q <= sync1_q;
    end
  end

  // blocked input reads low while floated, avoiding an open-input leak
  assign p.sampled = p.floated ? '0 : sync2_q;

  float_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
    p.floated |-> (p.pin_oe == '0) && (p.sampled == '0))
    else $error("pin driven or input open while floated");
  out_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!p.floated && lcd_own == '0) |->
      (p.pin_oe == p.dir) && ((p.pin_out & p.dir) == (p.latch & p.dir)))
    else $error("output pins do not follow the latch");
endmodule

// ==== logic/lgp_gpio.sv ====
// module: lcd-shared general purpose ports a and b with an axi4-lite slave
`timescale 1ns/10ps
module lgp_gpio (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output      logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output      logic               s_axi_wready,
  // axi4-lite write response
  output      logic [1:0]         s_axi_bresp,
  output      logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output      logic               s_axi_arready,
  output      logic [31:0]        s_axi_rdata,
  output      logic [1:0]         s_axi_rresp,
  output      logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // standby request from the clock controller
  input  wire logic               standby_mode,
  // display driver levels
  input  wire lgp_pkg::lgp_pa_t   lcd_common,
  input  wire lgp_pkg::lgp_pb_t   lcd_segment,
  // port a pins
  input  wire lgp_pkg::lgp_pa_t   port_a_in,
  output      lgp_pkg::lgp_pa_t   port_a_out,
  output      lgp_pkg::lgp_pa_t   port_a_oe,
  // port b pins
  input  wire lgp_pkg::lgp_pb_t   port_b_in,
  output      lgp_pkg::lgp_pb_t   port_b_out,
  output      lgp_pkg::lgp_pb_t   port_b_oe
);
  import lgp_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  lgp_pa_t          pa_latch_q;
  lgp_pa_t          pa_dir_q;
  lgp_pb_t          pb_latch_q;
  lgp_pb_t          pb_dir_q;
  lgp_pa_t          bp_sel_q;
  lgp_pb_t          seg_sel_q;
  logic             port_input_control_bit_q;
  logic             spl_q;
  logic             floated_q;
  logic             stby_sync1_q;
  logic             stby_sync2_q;

  // bus state
  logic             aw_held_q;
  logic             w_held_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic             wstrb0_q;
  logic             bvalid_q;
  logic [1:0]       bresp_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;
  logic [1:0]       rresp_q;
  logic             wr_go;
  logic             rd_go;
  logic             wr_hit;
  logic [31:0]      rd_d;
  logic             rd_hit;

  lgp_pin_if #(.W(LGP_PA_W)) pa_if ();
  lgp_pin_if #(.W(LGP_PB_W)) pb_if ();

  // ----------------------------------------------------------------
  // standby synchroniser and float state
  // ----------------------------------------------------------------
  // standby comes from another block, so it is synchronised first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stby_sync1_q <= 1'b0;
      stby_sync2_q <= 1'b0;
    end else begin
      stby_sync1_q <= standby_mode;
      stby_sync2_q <= stby_sync1_q;
    end
  end

  // float only with the float bit set; otherwise pins hold their state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      floated_q <= 1'b0;
    end else begin
      floated_q <= stby_sync2_q & spl_q;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data may arrive in either order; each is held once taken
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign wr_go         = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= LGP_ZERO32;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // writable offsets; rmw views and status are read only
  always_comb begin
    case (awaddr_q)
      LGP_PA_DATA_OFS, LGP_PA_DIR_OFS, LGP_PB_DATA_OFS, LGP_PB_DIR_OFS,
      LGP_CTRL_OFS, LGP_BP_SEL_OFS, LGP_SEG_SEL_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= LGP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? LGP_RESP_OKAY : LGP_RESP_SLV;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // ----------------------------------------------------------------
  // register updates
  // ----------------------------------------------------------------
  // latches load whatever the direction; only output pins show it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_latch_q <= LGP_DATA_RST;
      pb_latch_q <= LGP_DATA_RST[LGP_PB_W-1:0];
    end else if (wr_go && wstrb0_q) begin
      if (awaddr_q == LGP_PA_DATA_OFS)
        pa_latch_q <= wdata_q[LGP_PA_W-1:0];
      if (awaddr_q == LGP_PB_DATA_OFS)
        pb_latch_q <= wdata_q[LGP_PB_W-1:0];
    end
  end

  // direction registers clear on reset so every pin starts as input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_dir_q <= LGP_DIR_RST;
      pb_dir_q <= LGP_DIR_RST[LGP_PB_W-1:0];
    end else if (wr_go && wstrb0_q) begin
      if (awaddr_q == LGP_PA_DIR_OFS)
        pa_dir_q <= wdata_q[LGP_PA_W-1:0];
      if (awaddr_q == LGP_PB_DIR_OFS)
        pb_dir_q <= wdata_q[LGP_PB_W-1:0];
    end
  end

  // function select and control bits for display sharing and standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bp_sel_q  <= LGP_SEL_RST;
      seg_sel_q <= LGP_SEL_RST[LGP_PB_W-1:0];
      port_input_control_bit_q   <= LGP_CTRL_RST[LGP_CTRL_PORT_INPUT_CONTROL_BIT];
      spl_q     <= LGP_CTRL_RST[LGP_CTRL_SPL];
    end else if (wr_go && wstrb0_q) begin
      if (awaddr_q == LGP_BP_SEL_OFS)
        bp_sel_q <= wdata_q[LGP_PA_W-1:0];
      if (awaddr_q == LGP_SEG_SEL_OFS)
        seg_sel_q <= wdata_q[LGP_PB_W-1:0];
      if (awaddr_q == LGP_CTRL_OFS) begin
        port_input_control_bit_q <= wdata_q[LGP_CTRL_PORT_INPUT_CONTROL_BIT];
        spl_q   <= wdata_q[LGP_CTRL_SPL];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin slices
  // ----------------------------------------------------------------
  assign pa_if.latch   = pa_latch_q;
  assign pa_if.dir     = pa_dir_q;
  assign pa_if.lcd_sel = bp_sel_q;
  assign pa_if.lcd_val = lcd_common;
  assign pa_if.port_input_control_bit   = port_input_control_bit_q;
  assign pa_if.floated = floated_q;
  assign pa_if.pin_in  = port_a_in;
  assign pb_if.latch   = pb_latch_q;
  assign pb_if.dir     = pb_dir_q;
  assign pb_if.lcd_sel = seg_sel_q;
  assign pb_if.lcd_val = lcd_segment;
  assign pb_if.port_input_control_bit   = port_input_control_bit_q;
  assign pb_if.floated = floated_q;
  assign pb_if.pin_in  = port_b_in;

  lgp_pin_slice #(.W(LGP_PA_W)) u_port_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .p       (pa_if.pins)
  );

  lgp_pin_slice #(.W(LGP_PB_W)) u_port_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .p       (pb_if.pins)
  );

  assign port_a_out = pa_if.pin_out;
  assign port_a_oe  = pa_if.pin_oe;
  assign port_b_out = pb_if.pin_out;
  assign port_b_oe  = pb_if.pin_oe;

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  // plain reads mix latch (outputs) and pin (inputs); rmw views latch only
  always_comb begin
    rd_d   = LGP_ZERO32;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      LGP_PA_DATA_OFS:
        rd_d[LGP_PA_W-1:0] = (pa_latch_q & pa_dir_q)
                           | (pa_if.sampled & ~pa_dir_q);
      LGP_PB_DATA_OFS:
        rd_d[LGP_PB_W-1:0] = (pb_latch_q & pb_dir_q)
                           | (pb_if.sampled & ~pb_dir_q);
      LGP_PA_DIR_OFS:  rd_d[LGP_PA_W-1:0] = pa_dir_q;
      LGP_PB_DIR_OFS:  rd_d[LGP_PB_W-1:0] = pb_dir_q;
      LGP_PA_RMW_OFS:  rd_d[LGP_PA_W-1:0] = pa_latch_q;
      LGP_PB_RMW_OFS:  rd_d[LGP_PB_W-1:0] = pb_latch_q;
      LGP_BP_SEL_OFS:  rd_d[LGP_PA_W-1:0] = bp_sel_q;
      LGP_SEG_SEL_OFS: rd_d[LGP_PB_W-1:0] = seg_sel_q;
      LGP_CTRL_OFS: begin
        rd_d[LGP_CTRL_PORT_INPUT_CONTROL_BIT] = port_input_control_bit_q;
        rd_d[LGP_CTRL_SPL]   = spl_q;
      end
      LGP_STATUS_OFS: begin
        rd_d[LGP_STS_STBY]  = stby_sync2_q;
        rd_d[LGP_STS_FLOAT] = floated_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_q;
  assign rd_go         = s_axi_arvalid && !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= LGP_ZERO32;
      rresp_q  <= LGP_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_d;
      rresp_q  <= rd_hit ? LGP_RESP_OKAY : LGP_RESP_SLV;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence pa_data_write_s;
    wr_go && wstrb0_q && awaddr_q == LGP_PA_DATA_OFS;
  endsequence

  latch_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pa_data_write_s |=> pa_latch_q == $past(wdata_q[LGP_PA_W-1:0]))
    else $error("port a latch not loaded by write");
  out_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!floated_q && (bp_sel_q == '0) && pa_dir_q[0]) |->
      port_a_oe[0] && port_a_out[0] == pa_latch_q[0])
    else $error("port a output bit 0 does not show latch");
  in_no_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!floated_q && !pa_dir_q[1] && !(bp_sel_q[1] && port_input_control_bit_q)) |->
      !port_a_oe[1])
    else $error("input pin driven");
  rmw_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr == LGP_PB_RMW_OFS) |=>
      rdata_q == {27'h0, $past(pb_latch_q)})
    else $error("rmw read does not return latch");
  plain_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr == LGP_PA_DATA_OFS && pa_dir_q == 8'hFF) |=>
      rdata_q[7:0] == $past(pa_latch_q))
    else $error("output pin read does not return latch");
  pb_upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q && $past(rd_go) && $past(s_axi_araddr) == LGP_PB_DIR_OFS
      |-> rdata_q[31:LGP_PB_W] == '0)
    else $error("port b upper bits read nonzero");
  lcd_owns_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!floated_q && !pb_dir_q[2] && seg_sel_q[2] && port_input_control_bit_q) |->
      port_b_oe[2] && port_b_out[2] == lcd_segment[2])
    else $error("segment does not own port b pin");
  float_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (stby_sync2_q && spl_q) |=> port_a_oe == '0 && port_b_oe == '0)
    else $error("pins not floated in standby");
  hold_state_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!spl_q && $past(!spl_q)) |-> !floated_q)
    else $error("pins floated with float bit clear");
endmodule

// ==== bench/lgp_pin_model.sv ====
// partner model: board levels and display driver levels at the pins
`timescale 1ns/10ps
module lgp_pin_model (
  // clock
  input  wire logic             aclk,
  // board levels where the block does not drive
  input  wire lgp_pkg::lgp_pa_t ext_a,
  input  wire lgp_pkg::lgp_pb_t ext_b,
  // block pin drivers
  input  wire lgp_pkg::lgp_pa_t port_a_out,
  input  wire lgp_pkg::lgp_pa_t port_a_oe,
  input  wire lgp_pkg::lgp_pb_t port_b_out,
  input  wire lgp_pkg::lgp_pb_t port_b_oe,
  // resolved pin levels and display levels
  output      lgp_pkg::lgp_pa_t port_a_in,
  output      lgp_pkg::lgp_pb_t port_b_in,
  output      lgp_pkg::lgp_pa_t lcd_common,
  output      lgp_pkg::lgp_pb_t lcd_segment
);
  import lgp_pkg::*;
  lgp_pa_t lvl_q = 8'h00;
  // common levels move every cycle so a stale copy in the block never matches; segment levels can stay unchanged for four cycles
  always @(posedge aclk) begin
    lvl_q <= {lvl_q[6:0], ~lvl_q[7]};
  end
  assign lcd_common  = lvl_q;
  assign lcd_segment = lvl_q[4:0] ^ 5'h15;
  // a driving pin wins; otherwise the board holds its own level
  assign port_a_in = (port_a_out & port_a_oe) | (ext_a & ~port_a_oe);
  assign port_b_in = (port_b_out & port_b_oe) | (ext_b & ~port_b_oe);
endmodule

// ==== bench/lgp_gpio_tb_top.sv ====
// testbench: register bus, pin, display and standby checks of lgp_gpio
`timescale 1ns/10ps
module lgp_gpio_tb_top;
  import lgp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, xr = 32'h0000_0034;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, standby_mode = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  lgp_pa_t ext_a = 8'h5A, lcd_common, a_in, a_out, a_oe;
  lgp_pb_t ext_b = 5'h0C, lcd_segment, b_in, b_out, b_oe;
  logic [34:0] note_q[$];
  logic [34:0] note;
  int fails = 0, tests_run = 0;

  initial forever #12.5 aclk = ~aclk;

  lgp_gpio i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .standby_mode(standby_mode), .lcd_common(lcd_common),
    .lcd_segment(lcd_segment), .port_a_in(a_in), .port_a_out(a_out),
    .port_a_oe(a_oe), .port_b_in(b_in), .port_b_out(b_out),
    .port_b_oe(b_oe));

  lgp_pin_model i_pins (.aclk(aclk), .ext_a(ext_a), .ext_b(ext_b),
    .port_a_out(a_out), .port_a_oe(a_oe), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_a_in(a_in), .port_b_in(b_in),
    .lcd_common(lcd_common), .lcd_segment(lcd_segment));

  // ----------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------
  function automatic logic [31:0] rnd();
    xr = xr ^ (xr << 13);
    xr = xr ^ (xr >> 17);
    xr = xr ^ (xr << 5);
    return xr;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks made %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    note_q.push_back({1'b0, er, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ar_ok, r_ok;
    note_q.push_back({1'b1, er, ed});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // responses are judged against the oldest note, in issue order
  always @(negedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      note = note_q.pop_front();
      if (note[34]) check("rdata", rdata, note[31:0]);
      check("resp", {30'h0, note[34] ? rresp : bresp}, {30'h0, note[33:32]});
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    summarize();
  end

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [31:0] r, d, x;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("oe_a", {24'h0, a_oe}, 32'h0);
    wr(LGP_CTRL_OFS, 32'h1, 4'hF, LGP_RESP_OKAY);
    rd(LGP_PA_DIR_OFS, 32'h0, LGP_RESP_OKAY);
    rd(LGP_PB_DIR_OFS, 32'h0, LGP_RESP_OKAY);
    rd(LGP_PA_DATA_OFS, {24'h0, ext_a}, LGP_RESP_OKAY);
    rd(8'h28, 32'h0, LGP_RESP_SLV);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      d = rnd();
      x = rnd();
      ext_a <= x[7:0];
      ext_b <= x[12:8];
      wr(LGP_PA_DIR_OFS, {24'h0, r[7:0]}, 4'hF, LGP_RESP_OKAY);
      wr(LGP_PA_DATA_OFS, {24'h0, d[7:0]}, 4'hF, LGP_RESP_OKAY);
      wr(LGP_PB_DIR_OFS, {24'h0, r[15:8]}, 4'hF, LGP_RESP_OKAY);
      wr(LGP_PB_DATA_OFS, {24'h0, d[15:8]}, 4'hF, LGP_RESP_OKAY);
      @(negedge aclk);
      check("oe_a", {24'h0, a_oe}, {24'h0, r[7:0]});
      check("out_a", {24'h0, a_out & a_oe}, {24'h0, d[7:0] & r[7:0]});
      check("oe_b", {27'h0, b_oe}, {27'h0, r[12:8]});
      check("out_b", {27'h0, b_out & b_oe}, {27'h0, d[12:8] & r[12:8]});
      rd(LGP_PA_DATA_OFS, {24'h0, (d[7:0] & r[7:0]) | (x[7:0] & ~r[7:0])},
         LGP_RESP_OKAY);
      rd(LGP_PB_DATA_OFS, {27'h0, (d[12:8] & r[12:8]) | (x[12:8] & ~r[12:8])},
         LGP_RESP_OKAY);
      rd(LGP_PA_RMW_OFS, {24'h0, d[7:0]}, LGP_RESP_OKAY);
      rd(LGP_PB_RMW_OFS, {27'h0, d[12:8]}, LGP_RESP_OKAY);
      rd(LGP_PB_DIR_OFS, {27'h0, r[12:8]}, LGP_RESP_OKAY);
    end
    $display("test direction and data done");
    wr(LGP_PA_DIR_OFS, 32'h0, 4'hF, LGP_RESP_OKAY);
    wr(LGP_PB_DIR_OFS, 32'h0, 4'hF, LGP_RESP_OKAY);
    wr(LGP_CTRL_OFS, 32'h0, 4'hF, LGP_RESP_OKAY);
    wr(LGP_BP_SEL_OFS, 32'hFF, 4'hF, LGP_RESP_OKAY);
    wr(LGP_SEG_SEL_OFS, 32'h1F, 4'hF, LGP_RESP_OKAY);
    @(negedge aclk);
    check("oe_a", {24'h0, a_oe}, 32'h0);
    wr(LGP_CTRL_OFS, 32'h1, 4'hF, LGP_RESP_OKAY);
    repeat (3) begin
      @(negedge aclk);
      check("oe_a", {24'h0, a_oe}, 32'hFF);
      check("out_a", {24'h0, a_out}, {24'h0, lcd_common});
      check("oe_b", {27'h0, b_oe}, 32'h1F);
      check("out_b", {27'h0, b_out}, {27'h0, lcd_segment});
    end
    wr(LGP_BP_SEL_OFS, 32'h0, 4'hF, LGP_RESP_OKAY);
    wr(LGP_SEG_SEL_OFS, 32'h1C, 4'hF, LGP_RESP_OKAY);
    @(negedge aclk);
    check("oe_a", {24'h0, a_oe}, 32'h0);
    check("oe_b", {27'h0, b_oe}, 32'h1C);
    wr(LGP_SEG_SEL_OFS, 32'h0, 4'hF, LGP_RESP_OKAY);
    $display("test display sharing done");
    wr(LGP_PA_DIR_OFS, 32'h0F, 4'hF, LGP_RESP_OKAY);
    wr(LGP_PA_DATA_OFS, 32'h3C, 4'hF, LGP_RESP_OKAY);
    wr(LGP_CTRL_OFS, 32'h3, 4'hF, LGP_RESP_OKAY);
    standby_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check("oe_a", {24'h0, a_oe}, 32'h0);
    rd(LGP_PA_DATA_OFS, 32'h0C, LGP_RESP_OKAY);
    rd(LGP_STATUS_OFS, 32'h3, LGP_RESP_OKAY);
    standby_mode <= 1'b0;
    wr(LGP_CTRL_OFS, 32'h1, 4'hF, LGP_RESP_OKAY);
    standby_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check("oe_a", {24'h0, a_oe}, 32'h0F);
    check("out_a", {24'h0, a_out & a_oe}, 32'h0C);
    standby_mode <= 1'b0;
    $display("test standby done");
    wr(LGP_PA_DATA_OFS, 32'hFF, 4'hE, LGP_RESP_OKAY);
    wr(LGP_PA_RMW_OFS, 32'hFF, 4'hF, LGP_RESP_SLV);
    wr(8'h30, 32'hFF, 4'hF, LGP_RESP_SLV);
    rd(LGP_PA_RMW_OFS, 32'h3C, LGP_RESP_OKAY);
    wr(LGP_PA_DIR_OFS, 32'hFF, 4'hF, LGP_RESP_OKAY);
    rd(LGP_PA_DATA_OFS, 32'h3C, LGP_RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(LGP_PA_DIR_OFS, 32'h0, LGP_RESP_OKAY);
    $display("test refusals and second reset done");
    repeat (2) @(posedge aclk);
    summarize();
  end
endmodule
